// >>> src/uart_host_pkg.sv
// shared constants for the dual serial channel host port
package uart_host_pkg;

  // channel count and register offsets within a channel
  localparam int         NCH          = 2;
  localparam logic [2:0] A_DATA       = 3'h0;
  localparam logic [2:0] A_INT_EN     = 3'h1;
  localparam logic [2:0] A_INT_FIFO   = 3'h2;
  localparam logic [2:0] A_LINE_CTRL  = 3'h3;
  localparam logic [2:0] A_MODEM_CTRL = 3'h4;
  localparam logic [2:0] A_LINE_STAT  = 3'h5;
  localparam logic [2:0] A_MODEM_STAT = 3'h6;
  localparam logic [2:0] A_SCRATCH    = 3'h7;

  // line control value that opens the alternate-function register
  localparam logic [7:0] ALT_KEY      = 8'hBF;

  // field positions
  localparam int DIVLATCH_BIT = 7;
  localparam int FIFO_EN_BIT  = 0;
  localparam int RX_CLR_BIT   = 1;
  localparam int TX_CLR_BIT   = 2;
  localparam int BLOCK_BIT    = 3;
  localparam int OUT2_BIT     = 3;
  localparam int RX_IE_BIT    = 0;
  localparam int TX_IE_BIT    = 1;
  localparam int BCAST_BIT    = 0;

  // fifo control bits that are stored, clear bits self-clear
  localparam logic [7:0] FIFO_KEEP = 8'hF9;

  // multi-function output codes
  localparam logic [1:0] MF_RECEIVE_READY_N = 2'h2;
  localparam logic [1:0] MF_BAUD  = 2'h1;

  // fifo depths and receive trigger levels
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] HOLD_DEPTH = 5'h01;
  localparam logic [3:0][4:0] TRIG_LVL = {5'h0E, 5'h08, 5'h04, 5'h01};

  // interrupt status codes and reset values
  localparam logic [3:0] INT_NONE = 4'h1;
  localparam logic [3:0] INT_RXTO = 4'hC;
  localparam logic [3:0] INT_RXDA = 4'h4;
  localparam logic [3:0] INT_TXE  = 4'h2;
  localparam logic [7:0] REG_RST  = 8'h00;

  // reset pulse width
  localparam int RST_MIN_NS    = 40;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ?
                                 1 : (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> src/byte_fifo.sv
// sixteen-entry byte fifo used for each transmit and receive path
`timescale 1ns/1ps
module byte_fifo
  import uart_host_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // control
  input  wire logic       clear_in,
  input  wire logic       push_in,
  input  wire logic [7:0] push_data_in,
  input  wire logic       pop_in,
  // status
  output logic      [7:0] head_out,
  output logic      [4:0] count_out
);

  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [3:0]       wr;
    logic [3:0]       rd;
    logic [4:0]       cnt;
  } fifo_t;

  fifo_t st_q;
  fifo_t st_d;

  // pointers wrap naturally at sixteen; caller never pushes when full
  always_comb begin
    st_d = st_q;
    if (push_in) begin
      st_d.mem[st_q.wr] = push_data_in;
      st_d.wr = st_q.wr + 4'h1;
    end
    if (pop_in) begin
      st_d.rd = st_q.rd + 4'h1;
    end
    st_d.cnt = st_q.cnt + {4'h0, push_in} - {4'h0, pop_in};
    if (!rst_n_in || clear_in) begin
      st_d.wr  = 4'h0;
      st_d.rd  = 4'h0;
      st_d.cnt = 5'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    st_q <= st_d;
  end

  assign head_out  = st_q.mem[st_q.rd];
  assign count_out = st_q.cnt;

  // occupancy never passes the depth
  fifo_bound_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st_q.cnt <= FIFO_DEPTH)
    else $error("fifo count above depth");

endmodule

// >>> src/dual_uart_host_port.sv
// host bus front end, register sets and ready/interrupt pins of two serial channels
//
// Operation
// - host bus: 8 data bits, 3 address lines, chip select, read and write strobes
// - bus cycles are timed by select and strobes only, no oscillator needed
// - both channels share one data bus, each access goes to one channel except broadcast writes
// - reset longer than 40 ns returns registers and serial outputs to defaults
// - select high ignores bus; pick 1 means channel A, 0 means channel B
// - each channel owns a full register set with holding, control and status
// - broadcast bit 0 makes every write reach both channels
// - alternate bits choose receive-ready, general output two or baud clock
// - fifo control bit 3 picks single-character or block-transfer signalling
// - block mode receive-ready falls at trigger or timeout, rises when empty
// - block mode transmit-ready is high when full, low with any free slot
// - single-character fifo mode: transmit-ready low when empty, high with data
// - interrupt reflects transmit empty: holding register or whole fifo
// - with fifo, receive interrupt rises once the trigger level is reached
// - line status bits 5 and 6 report transmit room and transmitter empty
// - one oscillator feeds both baud generators, bus does not depend on it
// - during reset serial output held at 1, receive input ignored
`timescale 1ns/1ps
module dual_uart_host_port
  import uart_host_pkg::*;
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  // host bus
  input  wire logic                chip_select_n_in,
  input  wire logic                read_strobe_n_in,
  input  wire logic                write_strobe_n_in,
  input  wire logic [2:0]          addr_in,
  input  wire logic                channel_pick_in,
  input  wire logic [7:0]          data_in,
  output logic      [7:0]          data_out,
  output logic                     data_oe_out,
  // serial engine side, index 0 is channel A
  input  wire logic [NCH-1:0]      tx_pop_in,
  input  wire logic [NCH-1:0]      tsr_empty_in,
  input  wire logic [NCH-1:0]      tx_bit_in,
  input  wire logic [NCH-1:0]      rx_push_in,
  input  wire logic [NCH-1:0][7:0] rx_byte_in,
  input  wire logic [NCH-1:0]      rx_timeout_in,
  input  wire logic [NCH-1:0]      baud_tick_in,
  input  wire logic [NCH-1:0][7:0] modem_status_in,
  output logic      [NCH-1:0][7:0] tx_byte_out,
  output logic      [NCH-1:0][15:0] divisor_out,
  output logic      [NCH-1:0]      serial_tx_out,
  // oscillator
  input  wire logic                osc_in,
  output logic                     osc_out,
  // status pins
  output logic      [NCH-1:0]      transmit_ready_n_out,
  output logic      [NCH-1:0]      multi_function_n_out,
  output logic                     channel_a_irq_out,
  output logic                     channel_b_irq_out
);

  typedef enum logic {B_IDLE, B_HOLD} bus_t;

  typedef struct packed {
    bus_t                bus;
    logic [7:0]          dout;
    logic [7:0]          alt_func;
    logic [NCH-1:0][7:0] int_en;
    logic [NCH-1:0][7:0] line_ctrl;
    logic [NCH-1:0][7:0] modem_ctrl;
    logic [NCH-1:0][7:0] scratch;
    logic [NCH-1:0][7:0] div_low;
    logic [NCH-1:0][7:0] div_high;
    logic [NCH-1:0][7:0] fifo_ctrl;
    logic [NCH-1:0]      transmit_ready_n_n;
    logic [NCH-1:0]      receive_ready_n_n;
    logic [NCH-1:0]      irq;
    logic [NCH-1:0]      line;
    logic [NCH-1:0]      mf_n;
    logic [NCH-1:0]      baud_n;
  } st_t;

  st_t st_q;
  st_t st_d;

  // strobes of the current cycle and per-channel fifo controls
  logic                wr_go;
  logic                rd_go;
  logic                pick;
  logic [NCH-1:0]      we;
  logic [NCH-1:0]      tx_push;
  logic [NCH-1:0]      tx_pop;
  logic [NCH-1:0]      tx_clr;
  logic [NCH-1:0]      rx_push;
  logic [NCH-1:0]      rx_pop;
  logic [NCH-1:0]      rx_clr;
  logic [NCH-1:0]      tx_full;
  logic [NCH-1:0]      fen;
  logic [NCH-1:0]      blk;
  logic [NCH-1:0]      dlab;
  logic [NCH-1:0]      alt_open;
  logic [NCH-1:0]      rx_hit;
  logic [NCH-1:0][4:0] trig;
  logic [NCH-1:0][4:0] tx_cnt;
  logic [NCH-1:0][4:0] rx_cnt;
  logic [NCH-1:0][7:0] rx_head;
  logic [NCH-1:0][7:0] stat_v;
  logic [NCH-1:0][7:0] intid_v;
  logic [NCH-1:0][7:0] rd_v;

  // one transmit and one receive fifo per channel
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    byte_fifo u_tx (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .clear_in     (tx_clr[g]),
      .push_in      (tx_push[g]),
      .push_data_in (data_in),
      .pop_in       (tx_pop[g]),
      .head_out     (tx_byte_out[g]),
      .count_out    (tx_cnt[g])
    );
    byte_fifo u_rx (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .clear_in     (rx_clr[g]),
      .push_in      (rx_push[g]),
      .push_data_in (rx_byte_in[g]),
      .pop_in       (rx_pop[g]),
      .head_out     (rx_head[g]),
      .count_out    (rx_cnt[g])
    );
  end

  // whole next-state computation
  always_comb begin
    st_d  = st_q;
    wr_go = 1'h0;
    rd_go = 1'h0;
    // channel index: pick 1 is A (index 0), pick 0 is B
    pick  = ~channel_pick_in;
    // one action per strobe; strobes sampled, no oscillator involved
    case (st_q.bus)
      B_IDLE: begin
        if (!chip_select_n_in && !write_strobe_n_in) begin
          wr_go      = 1'h1;
          st_d.bus   = B_HOLD;
        end else if (!chip_select_n_in && !read_strobe_n_in) begin
          rd_go      = 1'h1;
          st_d.bus   = B_HOLD;
        end
      end
      B_HOLD: begin
        if (chip_select_n_in || (read_strobe_n_in && write_strobe_n_in)) begin
          st_d.bus = B_IDLE;
        end
      end
      default: begin
        st_d.bus = B_IDLE;
      end
    endcase

    for (int ch = 0; ch < NCH; ch++) begin
      fen[ch]      = st_q.fifo_ctrl[ch][FIFO_EN_BIT];
      blk[ch]      = fen[ch] && st_q.fifo_ctrl[ch][BLOCK_BIT];
      dlab[ch]     = st_q.line_ctrl[ch][DIVLATCH_BIT];
      alt_open[ch] = st_q.line_ctrl[ch] == ALT_KEY;
      trig[ch]     = TRIG_LVL[st_q.fifo_ctrl[ch][7:6]];
      // fifo off behaves as a single holding register
      tx_full[ch]  = tx_cnt[ch] >= (fen[ch] ? FIFO_DEPTH : HOLD_DEPTH);
      rx_hit[ch]   = fen[ch] ? (rx_cnt[ch] >= trig[ch]) ||
                     (rx_timeout_in[ch] && rx_cnt[ch] != 5'h00) :
                     rx_cnt[ch] != 5'h00;
      // broadcast only applies to writes, reads keep the pick
      we[ch]       = wr_go && (st_q.alt_func[BCAST_BIT] || pick == 1'(ch));
      tx_push[ch]  = we[ch] && addr_in == A_DATA && !dlab[ch] && !tx_full[ch];
      tx_pop[ch]   = tx_pop_in[ch] && tx_cnt[ch] != 5'h00;
      // receive side ignored while reset is held
      rx_push[ch]  = rst_n_in && rx_push_in[ch] &&
                     rx_cnt[ch] < (fen[ch] ? FIFO_DEPTH : HOLD_DEPTH);
      rx_pop[ch]   = rd_go && pick == 1'(ch) && addr_in == A_DATA &&
                     !dlab[ch] && rx_cnt[ch] != 5'h00;
      tx_clr[ch]   = !rst_n_in;
      rx_clr[ch]   = !rst_n_in;

      // line status: room in transmitter, transmitter empty, data ready
      stat_v[ch]   = {1'h0, tx_cnt[ch] == 5'h00 && tsr_empty_in[ch],
                      tx_cnt[ch] == 5'h00, 4'h0, rx_cnt[ch] != 5'h00};
      // interrupt identity, receive has priority over transmit
      intid_v[ch]  = {{2{fen[ch]}}, 2'h0, INT_NONE};
      if (st_q.int_en[ch][RX_IE_BIT] && rx_hit[ch]) begin
        intid_v[ch][3:0] = (rx_timeout_in[ch] && rx_cnt[ch] != 5'h00) ?
                           INT_RXTO : INT_RXDA;
      end else if (st_q.int_en[ch][TX_IE_BIT] && tx_cnt[ch] == 5'h00) begin
        intid_v[ch][3:0] = INT_TXE;
      end

      // eight locations per channel
      case (addr_in)
        A_DATA:       rd_v[ch] = dlab[ch] ? st_q.div_low[ch] : rx_head[ch];
        A_INT_EN:     rd_v[ch] = dlab[ch] ? st_q.div_high[ch] : st_q.int_en[ch];
        A_INT_FIFO:   rd_v[ch] = alt_open[ch] ? st_q.alt_func : intid_v[ch];
        A_LINE_CTRL:  rd_v[ch] = st_q.line_ctrl[ch];
        A_MODEM_CTRL: rd_v[ch] = st_q.modem_ctrl[ch];
        A_LINE_STAT:  rd_v[ch] = stat_v[ch];
        A_MODEM_STAT: rd_v[ch] = modem_status_in[ch];
        A_SCRATCH:    rd_v[ch] = st_q.scratch[ch];
        default:      rd_v[ch] = REG_RST;
      endcase

      // register writes for this channel
      if (we[ch]) begin
        case (addr_in)
          A_DATA: begin
            if (dlab[ch]) begin
              st_d.div_low[ch] = data_in;
            end
          end
          A_INT_EN: begin
            if (dlab[ch]) begin
              st_d.div_high[ch] = data_in;
            end else begin
              st_d.int_en[ch] = data_in;
            end
          end
          A_INT_FIFO: begin
            if (alt_open[ch]) begin
              st_d.alt_func = data_in;
            end else begin
              st_d.fifo_ctrl[ch] = data_in & FIFO_KEEP;
              // toggling the fifo enable flushes both fifos
              tx_clr[ch] = data_in[TX_CLR_BIT] ||
                           data_in[FIFO_EN_BIT] != fen[ch];
              rx_clr[ch] = data_in[RX_CLR_BIT] ||
                           data_in[FIFO_EN_BIT] != fen[ch];
            end
          end
          A_LINE_CTRL:  st_d.line_ctrl[ch] = data_in;
          A_MODEM_CTRL: st_d.modem_ctrl[ch] = data_in;
          A_SCRATCH:    st_d.scratch[ch] = data_in;
          default: begin
            st_d.scratch[ch] = st_q.scratch[ch];
          end
        endcase
      end

      // transmit-ready pin by fifo mode
      if (blk[ch]) begin
        st_d.transmit_ready_n_n[ch] = tx_cnt[ch] == FIFO_DEPTH;
      end else begin
        st_d.transmit_ready_n_n[ch] = tx_cnt[ch] != 5'h00;
      end

      // receive-ready: block mode latches low until the fifo empties
      if (rx_cnt[ch] == 5'h00) begin
        st_d.receive_ready_n_n[ch] = 1'h1;
      end else if (!blk[ch] || rx_cnt[ch] >= trig[ch] || rx_timeout_in[ch]) begin
        st_d.receive_ready_n_n[ch] = 1'h0;
      end

      // interrupt pin: transmit empty or receive data per enables
      st_d.irq[ch] = (st_q.int_en[ch][TX_IE_BIT] && tx_cnt[ch] == 5'h00) ||
                     (st_q.int_en[ch][RX_IE_BIT] && rx_hit[ch]);

      // serial line and baud clock from the engine
      st_d.line[ch]   = tx_bit_in[ch];
      st_d.baud_n[ch] = ~baud_tick_in[ch];

      // shared multi-function pin; baud code sits on bits 1:0
      if (st_q.alt_func[2:1] == MF_RECEIVE_READY_N) begin
        st_d.mf_n[ch] = st_q.receive_ready_n_n[ch];
      end else if (st_q.alt_func[1:0] == MF_BAUD) begin
        st_d.mf_n[ch] = st_q.baud_n[ch];
      end else begin
        st_d.mf_n[ch] = ~st_q.modem_ctrl[ch][OUT2_BIT];
      end
    end

    // reads follow the pick even in broadcast mode
    if (rd_go) begin
      st_d.dout = rd_v[pick];
    end

    // one sampled low edge exceeds the 40 ns minimum at this rate
    if (!rst_n_in) begin
      st_d            = '0;
      st_d.bus        = B_IDLE;
      st_d.alt_func   = REG_RST;
      st_d.line       = '1;
      st_d.receive_ready_n_n    = '1;
      st_d.mf_n       = '1;
      st_d.baud_n     = '1;
    end
  end

  always_ff @(posedge clk_in) begin
    st_q <= st_d;
  end

  // output drive, data pins straight from flip-flops, their enable straight from select and read strobe
  assign data_out             = st_q.dout;
  assign data_oe_out          = !chip_select_n_in && !read_strobe_n_in;
  assign serial_tx_out        = st_q.line;
  assign transmit_ready_n_out = st_q.transmit_ready_n_n;
  assign multi_function_n_out = st_q.mf_n;
  assign channel_a_irq_out    = st_q.irq[0];
  assign channel_b_irq_out    = st_q.irq[1];
  // crystal input buffered out for both baud generators
  assign osc_out              = osc_in;

  for (genvar g = 0; g < NCH; g++) begin : g_div
    assign divisor_out[g] = {st_q.div_high[g], st_q.div_low[g]};
  end

  // deselected bus never drives
  bus_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    chip_select_n_in |-> !data_oe_out)
    else $error("data bus driven while deselected");

  // reset forces line high and clears alternate bits
  reset_state_a: assert property (@(posedge clk_in)
    !rst_n_in |=> (serial_tx_out == 2'h3 && st_q.alt_func == 8'h00))
    else $error("reset left line or registers set");

  // broadcast write lands in both scratch registers
  bcast_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_go && st_q.alt_func[BCAST_BIT] && addr_in == A_SCRATCH) |=>
    (st_q.scratch[0] == $past(data_in) && st_q.scratch[1] == $past(data_in)))
    else $error("broadcast write missed a channel");

  // read of channel B scratch follows the pick
  pick_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_go && !channel_pick_in && addr_in == A_SCRATCH) |=>
    data_out == $past(st_q.scratch[1]))
    else $error("read did not follow channel pick");

  // block mode transmit-ready high when full
  tx_block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (blk[0] && tx_cnt[0] == FIFO_DEPTH) |=> transmit_ready_n_out[0])
    else $error("transmit-ready low with full fifo");

  // single-character mode transmit-ready low when empty
  tx_single_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (fen[0] && !blk[0] && tx_cnt[0] == 5'h00) |=> !transmit_ready_n_out[0])
    else $error("transmit-ready high with empty fifo");

  // fifo off: loaded holding register raises transmit-ready
  tx_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!fen[0] && tx_cnt[0] != 5'h00) |=> transmit_ready_n_out[0])
    else $error("transmit-ready low with loaded holding register");

  // block mode receive-ready falls at trigger, rises on empty
  rx_trigger_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (blk[0] && rx_cnt[0] >= trig[0] && rx_cnt[0] != 5'h00) |=> !st_q.receive_ready_n_n[0])
    else $error("receive-ready missed the trigger");

  rx_empty_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rx_cnt[0] == 5'h00) |=> st_q.receive_ready_n_n[0])
    else $error("receive-ready low with empty fifo");

  // transmit empty raises the enabled interrupt
  tx_irq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_q.int_en[0][TX_IE_BIT] && tx_cnt[0] == 5'h00) |=> channel_a_irq_out)
    else $error("interrupt low with transmitter empty");

  // receive trigger raises the enabled interrupt
  rx_irq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (fen[0] && st_q.int_en[0][RX_IE_BIT] && rx_cnt[0] >= trig[0]) |=> channel_a_irq_out)
    else $error("interrupt low at receive trigger");

  // multi-function pin copies receive-ready in that code
  mf_select_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_q.alt_func[2:1] == MF_RECEIVE_READY_N) |=> multi_function_n_out[0] == $past(st_q.receive_ready_n_n[0]))
    else $error("multi-function pin not receive-ready");

  // line status read shows transmit room
  stat_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_go && channel_pick_in && addr_in == A_LINE_STAT) |=>
    data_out[5] == $past(tx_cnt[0] == 5'h00))
    else $error("line status room bit wrong");

endmodule

// >>> verification/host_cpu_model.sv
// host processor model that runs cycles on the parallel register bus
`timescale 1ns/1ps
module host_cpu_model (
  // clock
  input  wire logic       clk_in,
  // bus toward the device
  output logic            chip_select_n_out,
  output logic            read_strobe_n_out,
  output logic            write_strobe_n_out,
  output logic      [2:0] addr_out,
  output logic            channel_pick_out,
  output logic      [7:0] wdata_out,
  input  wire logic [7:0] rdata_in
);
  // idle bus from time zero
  initial begin
    chip_select_n_out  = 1'b1;
    read_strobe_n_out  = 1'b1;
    write_strobe_n_out = 1'b1;
    addr_out           = 3'h0;
    channel_pick_out   = 1'b1;
    wdata_out          = 8'h00;
  end

  // one cycle: held over the taking edge and the answer edge, then one idle edge
  task automatic access(input logic is_read, input logic sel_n, input logic pick,
                        input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    chip_select_n_out  <= sel_n;
    read_strobe_n_out  <= ~is_read;
    write_strobe_n_out <= is_read;
    addr_out           <= a;
    channel_pick_out   <= pick;
    wdata_out          <= d;
    repeat (2) @(posedge clk_in);
    q = rdata_in;
    chip_select_n_out  <= 1'b1;
    read_strobe_n_out  <= 1'b1;
    write_strobe_n_out <= 1'b1;
    wdata_out          <= ~d; // released lines must not keep the old value
    @(posedge clk_in);
  endtask
endmodule

// >>> verification/tb_dual_uart_host_port.sv
// self-checking bench for the dual channel host port
`timescale 1ns/1ps
module tb_dual_uart_host_port;
  import uart_host_pkg::*;
  logic clk_in, rst_n_in, cs_n, rd_n, wr_n, pick, osc, irq_a, irq_b, oe, osc_o;
  logic [NCH-1:0][15:0] div;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, q;
  logic [NCH-1:0] tx_pop, tsr_empty, tx_bit, rx_push, rx_timeout, baud, ser, txr_n, mf_n;
  logic [NCH-1:0][7:0] rx_byte, mstat, tx_byte;
  int fail_count, cmp_count;

  host_cpu_model host_u (.clk_in(clk_in), .chip_select_n_out(cs_n), .read_strobe_n_out(rd_n),
    .write_strobe_n_out(wr_n), .addr_out(addr), .channel_pick_out(pick),
    .wdata_out(wdata), .rdata_in(rdata));

  dual_uart_host_port dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(cs_n),
    .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .addr_in(addr), .channel_pick_in(pick),
    .data_in(wdata), .data_out(rdata), .data_oe_out(oe), .tx_pop_in(tx_pop),
    .tsr_empty_in(tsr_empty), .tx_bit_in(tx_bit), .rx_push_in(rx_push), .rx_byte_in(rx_byte),
    .rx_timeout_in(rx_timeout), .baud_tick_in(baud), .modem_status_in(mstat),
    .tx_byte_out(tx_byte), .divisor_out(div), .serial_tx_out(ser), .osc_in(osc), .osc_out(osc_o),
    .transmit_ready_n_out(txr_n), .multi_function_n_out(mf_n),
    .channel_a_irq_out(irq_a), .channel_b_irq_out(irq_b));

  // free-running 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic complete_run;
    $display("compared %0d mismatched %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic p, input logic [2:0] a, input logic [7:0] d);
    host_u.access(1'b0, 1'b0, p, a, d, q);
  endtask

  task automatic rd_chk(input logic p, input logic [2:0] a, input logic [7:0] e);
    host_u.access(1'b1, 1'b0, p, a, 8'h00, q);
    check(q, e);
  endtask

  // status pins lag the bus by up to three edges
  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // one-cycle pulse from the serial engine of channel A
  task automatic engine(input logic is_rx, input logic [7:0] b);
    @(posedge clk_in);
    rx_byte[0] <= b;
    if (is_rx) rx_push <= 2'b01;
    else tx_pop <= 2'b01;
    @(posedge clk_in);
    rx_push <= 2'b00;
    tx_pop  <= 2'b00;
    settle();
  endtask

  // broadcast writes leave both line controls at the key, so both are cleared after
  task automatic alt_set(input logic [7:0] v);
    wr(1'b1, A_LINE_CTRL, ALT_KEY);
    wr(1'b1, A_INT_FIFO, v);
    wr(1'b1, A_LINE_CTRL, 8'h00);
    wr(1'b0, A_LINE_CTRL, 8'h00);
  endtask

  // bound on the whole run
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    complete_run();
  end

  initial begin
    fail_count = 0;
    cmp_count  = 0;
    rst_n_in   = 1'b0;
    {tx_pop, rx_push, rx_timeout, baud, tx_bit} = '0;
    tsr_empty  = 2'b11;
    rx_byte    = '0;
    mstat      = {8'h3C, 8'hC3};
    osc        = 1'b0;
    // five sampled low edges in all, the release edge included
    repeat (4) @(posedge clk_in);
    #1;
    check({ser, txr_n, mf_n, irq_a, irq_b}, 8'hCC);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    settle();
    check(ser, 2'b00);
    rd_chk(1'b1, A_LINE_STAT, 8'h60);
    tsr_empty <= 2'b10;
    osc       <= 1'b1;
    rd_chk(1'b1, A_LINE_STAT, 8'h20);
    rd_chk(1'b0, A_LINE_STAT, 8'h60);
    check(osc_o, 1'b1);
    tsr_empty <= 2'b11;
    $display("test reset done");
    // separate register sets and channel steering
    wr(1'b1, A_SCRATCH, 8'h5A);
    wr(1'b0, A_SCRATCH, 8'hA5);
    host_u.access(1'b0, 1'b1, 1'b1, A_SCRATCH, 8'hFF, q);
    // output enable looked at while the read strobe is held low
    fork
      rd_chk(1'b1, A_SCRATCH, 8'h5A);
      begin
        repeat (2) @(posedge clk_in);
        #1;
        check(oe, 1'b1);
      end
    join
    check(oe, 1'b0);
    rd_chk(1'b0, A_SCRATCH, 8'hA5);
    rd_chk(1'b1, A_MODEM_STAT, 8'hC3);
    rd_chk(1'b0, A_MODEM_STAT, 8'h3C);
    // divisor latch pair behind the latch-access bit, channel B untouched
    wr(1'b1, A_LINE_CTRL, 8'h80);
    wr(1'b1, A_DATA, 8'h34);
    wr(1'b1, A_INT_EN, 8'h12);
    check(div[0], 16'h1234);
    rd_chk(1'b1, A_INT_EN, 8'h12);
    wr(1'b1, A_LINE_CTRL, 8'h00);
    check(div[1], 16'h0000);
    // broadcast on while both channels idle; code 01 routes the baud clock
    alt_set(8'h01);
    rd_chk(1'b1, A_SCRATCH, 8'h5A);
    rd_chk(1'b0, A_SCRATCH, 8'hA5);
    wr(1'b0, A_SCRATCH, 8'h3C);
    rd_chk(1'b1, A_SCRATCH, 8'h3C);
    baud <= 2'b01;
    settle();
    check(mf_n, 2'b10);
    baud <= 2'b00;
    alt_set(8'h00);
    wr(1'b1, A_MODEM_CTRL, 8'h08);
    settle();
    check(mf_n, 2'b10);
    wr(1'b0, A_SCRATCH, 8'h77);
    rd_chk(1'b1, A_SCRATCH, 8'h3C);
    alt_set(8'h04);
    $display("test steering done");
    // holding register without fifo
    wr(1'b1, A_INT_EN, 8'h02);
    settle();
    check({txr_n[0], irq_a}, 2'b01);
    wr(1'b1, A_DATA, 8'h55);
    settle();
    check({txr_n[0], irq_a, tx_byte[0]}, 10'h255);
    rd_chk(1'b1, A_LINE_STAT, 8'h00);
    engine(1'b0, 8'h00);
    check({txr_n[0], irq_a}, 2'b01);
    wr(1'b1, A_INT_EN, 8'h00);
    // single-character fifo mode, trigger level 4
    wr(1'b1, A_INT_FIFO, 8'h41);
    wr(1'b1, A_DATA, 8'h11);
    settle();
    check(txr_n[0], 1'b1);
    engine(1'b0, 8'h00);
    check(txr_n[0], 1'b0);
    engine(1'b1, 8'h99);
    check(mf_n, 2'b10);
    rd_chk(1'b1, A_DATA, 8'h99);
    $display("test single mode done");
    // block mode
    wr(1'b1, A_INT_FIFO, 8'h49);
    for (int i = 0; i < 16; i++) begin
      settle();
      check(txr_n[0], 1'b0);
      wr(1'b1, A_DATA, 8'(i));
    end
    settle();
    check(txr_n[0], 1'b1);
    engine(1'b0, 8'h00);
    check(txr_n[0], 1'b0);
    wr(1'b1, A_INT_EN, 8'h01);
    for (int i = 0; i < 4; i++) begin
      check({mf_n[0], irq_a}, 2'b10);
      engine(1'b1, 8'(8'hE0 + i));
    end
    check({mf_n, irq_a, irq_b}, 4'b1010);
    for (int i = 0; i < 4; i++) begin
      check(mf_n[0], 1'b0);
      rd_chk(1'b1, A_DATA, 8'(8'hE0 + i));
      settle();
    end
    check({mf_n, irq_a, irq_b}, 4'b1100);
    // one byte, three below the trigger of 4: only the receive timeout pulls the pin
    engine(1'b1, 8'h42);
    check(mf_n[0], 1'b1);
    @(posedge clk_in);
    rx_timeout <= 2'b01;
    settle();
    check({mf_n[0], irq_a}, 2'b01);
    rd_chk(1'b1, A_INT_FIFO, {4'hC, INT_RXTO});
    rx_timeout <= 2'b00;
    rd_chk(1'b1, A_DATA, 8'h42);
    settle();
    check(mf_n[0], 1'b1);
    $display("test block mode done");
    // mid-run reset while the receive engine keeps pushing
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    rx_push  <= 2'b11;
    repeat (4) @(posedge clk_in);
    #1;
    check({ser, mf_n, irq_a}, 5'h1E);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    rx_push  <= 2'b00;
    settle();
    rd_chk(1'b1, A_LINE_STAT, 8'h60);
    rd_chk(1'b0, A_LINE_STAT, 8'h60);
    rd_chk(1'b1, A_SCRATCH, 8'h00);
    check({ser, mf_n, irq_a}, 5'h06);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
